/* core/sch_host_port.sv */
// host side handshake and status pins of the storage card controller
`timescale 1ns/100ps
// What this block does
// RQ1 - wait low holds off card cycle in progress
// RQ2 - task mode ready flow control, never under udma
// RQ3 - ready to receive on write burst, may pause
// RQ4 - device drives data strobe, host latches both edges
// RQ5 - stop strobe edges to pause, resume later
// RQ6 - memory mode write enable strobes task registers
// RQ7 - io mode write enable only for config
// RQ8 - task mode ignores write enable, tied high
// RQ9 - write protect low after reset initialization; code drives wp low in memory mode only, high in io and task mode
// RQ10 - io mode 16-bit port indication low
// RQ11 - task mode word transfer indication low
// RQ12 - host stop ends current ultra dma burst
// RQ13 - ready low during reset, high when free
// RQ14 - pin function chosen by active interface mode
module sch_host_port (
  input wire logic clock,
  input wire logic srst,
  input wire logic mode_sel_task_n,
  input wire logic mode_sel_io,
  input wire logic we_n,
  input wire logic iowr_n,
  input wire logic stop,
  input wire logic core_busy,
  input wire logic core_hold,
  input wire logic core_word_cycle,
  input wire logic core_port16,
  input wire logic udma_start_recv,
  input wire logic udma_start_send,
  input wire logic core_recv_pause,
  input wire logic core_send_pause,
  input wire logic [sch_pkg::SCH_DATA_W-1:0] core_send_data,
  output logic wait_n,
  output logic ready,
  output logic ddmardy_n,
  output logic dstrobe,
  output logic [sch_pkg::SCH_DATA_W-1:0] data_out,
  output logic wp,
  output logic iois16_n,
  output logic iocs16_n,
  output logic cfg_write,
  output logic task_write,
  output logic send_taken,
  output logic burst_done
);
  import sch_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // synchronised pins
  logic [4:0] pin_s;
  logic task_sel_n_s, io_sel_s, we_n_s, iowr_n_s, stop_s;
  sch_sync #(.W(5), .RST_VAL(SCH_PIN_IDLE)) u_sync (
    .clock(clock),
    .srst(srst),
    .async_in({mode_sel_task_n, mode_sel_io, we_n, iowr_n, stop}),
    .sync_out(pin_s)
  );
  assign {task_sel_n_s, io_sel_s, we_n_s, iowr_n_s, stop_s} = pin_s;

  // state
  sch_mode_t mode_q; // active interface mode
  sch_ud_state_t ud_q; // ultra dma burst state
  logic [SCH_CNT_W-1:0] init_cnt_q; // init countdown
  logic init_done_q; // reset initialization complete
  logic [3:0] div_q; // strobe rate divider
  logic we_n_d1_q, iowr_n_d1_q; // previous strobe levels

  // mode decode used by the mode register process
  function automatic sch_mode_t decode_mode(input logic task_n, input logic io);
    if (!task_n)
      return SCH_MODE_TASK;
    else if (io)
      return SCH_MODE_IO;
    else
      return SCH_MODE_MEM;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // mode register, changes only while idle
  always_ff @(posedge clock)
  begin
    if (srst)
      mode_q <= SCH_MODE_MEM;
    else if (ud_q == SCH_UD_IDLE)
      mode_q <= decode_mode(task_sel_n_s, io_sel_s); // RQ14
  end

  ////////////////////////////////////////////////////////////////////////
  // reset initialization countdown
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      init_cnt_q <= SCH_CNT_W'(SCH_INIT_CYCLES);
      init_done_q <= 1'b0;
    end
    else if (init_cnt_q != SCH_CNT_ZERO)
      init_cnt_q <= init_cnt_q - SCH_CNT_ONE;
    else
      init_done_q <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // ultra dma burst control, task mode only
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ud_q <= SCH_UD_IDLE;
      burst_done <= 1'b0;
    end
    else
    begin
      burst_done <= 1'b0;
      case (ud_q)
        SCH_UD_IDLE:
        begin
          // start only in task mode, after init
          if (mode_q == SCH_MODE_TASK && init_done_q && !stop_s)
          begin
            if (udma_start_recv)
              ud_q <= SCH_UD_RECV;
            else if (udma_start_send)
              ud_q <= SCH_UD_SEND;
          end
        end
        SCH_UD_RECV, SCH_UD_SEND:
        begin
          // host stop ends burst
          if (stop_s)
          begin
            ud_q <= SCH_UD_IDLE; // RQ12
            burst_done <= 1'b1;
          end
        end
        default:
          ud_q <= SCH_UD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive readiness, negated to pause
  always_ff @(posedge clock)
  begin
    if (srst)
      ddmardy_n <= 1'b1;
    else
      ddmardy_n <= !(ud_q == SCH_UD_RECV && !stop_s && !core_recv_pause); // RQ3
  end

  ////////////////////////////////////////////////////////////////////////
  // strobe divider, enable pulse every SCH_STROBE_DIV plus one (4) cycles while sending
  logic strobe_en;
  assign strobe_en = (div_q == SCH_DIV_ZERO);
  always_ff @(posedge clock)
  begin
    if (srst || ud_q != SCH_UD_SEND)
      div_q <= SCH_STROBE_DIV;
    else if (strobe_en)
      div_q <= SCH_STROBE_DIV;
    else
      div_q <= div_q - SCH_DIV_ONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // data strobe: each edge while sending carries one word, pause stops edges, idle returns it low
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      dstrobe <= 1'b0;
      data_out <= '0;
      send_taken <= 1'b0;
    end
    else
    begin
      send_taken <= 1'b0;
      if (ud_q == SCH_UD_SEND && strobe_en && !stop_s && !core_send_pause) // RQ5
      begin
        dstrobe <= !dstrobe; // RQ4
        data_out <= core_send_data;
        send_taken <= 1'b1;
      end
      else if (ud_q == SCH_UD_IDLE)
        dstrobe <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wait line: card hold in card modes, iordy in task mode without udma
  always_ff @(posedge clock)
  begin
    if (srst)
      wait_n <= 1'b1;
    else if (mode_q == SCH_MODE_TASK)
      wait_n <= (ud_q != SCH_UD_IDLE) ? 1'b1 : !core_hold; // RQ2
    else
      wait_n <= !core_hold; // RQ1
  end

  ////////////////////////////////////////////////////////////////////////
  // ready and write protect status
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ready <= 1'b0;
      wp <= 1'b1;
    end
    else
    begin
      ready <= init_done_q && !core_busy; // RQ13
      wp <= (mode_q == SCH_MODE_MEM) ? !init_done_q : 1'b1; // RQ9
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 16-bit indications
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      iois16_n <= 1'b1;
      iocs16_n <= 1'b1;
    end
    else
    begin
      iois16_n <= !(mode_q == SCH_MODE_IO && core_port16); // RQ10
      iocs16_n <= !(mode_q == SCH_MODE_TASK && core_word_cycle); // RQ11
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write strobe routing on rising edge of each strobe
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      we_n_d1_q <= 1'b1;
      iowr_n_d1_q <= 1'b1;
      cfg_write <= 1'b0;
      task_write <= 1'b0;
    end
    else
    begin
      we_n_d1_q <= we_n_s;
      iowr_n_d1_q <= iowr_n_s;
      cfg_write <= 1'b0;
      task_write <= 1'b0;
      case (mode_q)
        SCH_MODE_MEM:
        begin
          // write enable strobes task and config writes
          cfg_write <= we_n_s && !we_n_d1_q;
          task_write <= we_n_s && !we_n_d1_q; // RQ6
        end
        SCH_MODE_IO:
        begin
          cfg_write <= we_n_s && !we_n_d1_q; // RQ7
          task_write <= iowr_n_s && !iowr_n_d1_q; // RQ7
        end
        SCH_MODE_TASK:
          task_write <= iowr_n_s && !iowr_n_d1_q; // RQ8
        default:
        begin
          cfg_write <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  wait_udma_a: assert property ((mode_q == SCH_MODE_TASK && ud_q != SCH_UD_IDLE) |=> wait_n) // RQ2
    else $error("wait driven during ultra dma");
  wait_hold_a: assert property ((mode_q != SCH_MODE_TASK && core_hold) |=> !wait_n) // RQ1
    else $error("wait not low on hold");
  rdy_recv_a: assert property ((ud_q != SCH_UD_RECV) |=> ddmardy_n) // RQ3
    else $error("ready to receive outside write burst");
  strobe_pause_a: assert property ((core_send_pause && ud_q == SCH_UD_SEND) |=> $stable(dstrobe)) // RQ5
    else $error("strobe moved during pause");
  strobe_edge_a: assert property ($changed(dstrobe) && ud_q == SCH_UD_SEND |-> send_taken) // RQ4
    else $error("strobe edge without word");
  stop_end_a: assert property ((ud_q != SCH_UD_IDLE && stop_s) |=> ud_q == SCH_UD_IDLE && burst_done) // RQ12
    else $error("stop did not end burst");
  ready_init_a: assert property (!init_done_q |=> !ready) // RQ13
    else $error("ready high before init");
  wp_low_a: assert property ((mode_q == SCH_MODE_MEM && $past(init_done_q) && $past(mode_q) == SCH_MODE_MEM) |-> !wp) // RQ9
    else $error("write protect not low");
  io16_mode_a: assert property ((mode_q != SCH_MODE_IO) |=> iois16_n) // RQ10
    else $error("16-bit port outside io mode");
  cs16_mode_a: assert property ((mode_q == SCH_MODE_TASK && core_word_cycle) |=> !iocs16_n) // RQ11
    else $error("word cycle not flagged");
  task_we_a: assert property ((mode_q == SCH_MODE_TASK) |=> !cfg_write) // RQ8
    else $error("write enable used in task mode");
  io_we_a: assert property ((mode_q == SCH_MODE_IO && $rose(we_n_s)) |=> cfg_write && !task_write) // RQ7
    else $error("io write enable misrouted");
  mem_we_a: assert property ((mode_q == SCH_MODE_MEM && $rose(we_n_s)) |=> task_write) // RQ6
    else $error("memory write not strobed");

  send_burst_c: cover property (ud_q == SCH_UD_SEND ##1 send_taken ##[1:8] send_taken);
  recv_pause_c: cover property (!ddmardy_n ##1 ddmardy_n ##1 !ddmardy_n);
  stop_c: cover property (burst_done);
  io_cfg_c: cover property (mode_q == SCH_MODE_IO && cfg_write);
endmodule

/* pkg/sch_pkg.sv */
// shared constants and types for the storage card host handshake block
package sch_pkg;
  // interface mode selected from the mode pins
  typedef enum logic [1:0] {SCH_MODE_MEM, SCH_MODE_IO, SCH_MODE_TASK} sch_mode_t;
  // ultra dma burst states
  typedef enum logic [1:0] {SCH_UD_IDLE, SCH_UD_RECV, SCH_UD_SEND} sch_ud_state_t;
  // reset initialization time in ns and its cycle count at 100 MHz
  localparam int SCH_CLK_PERIOD_NS = 10;
  localparam int SCH_INIT_TIME_NS = 2000;
  localparam int SCH_INIT_CYCLES = (SCH_INIT_TIME_NS + SCH_CLK_PERIOD_NS - 1) / SCH_CLK_PERIOD_NS;
  localparam int SCH_CNT_W = 12;
  // data word width on the host bus
  localparam int SCH_DATA_W = 16;
  // strobe divider, strobe toggles at most once every this many cycles plus one
  localparam logic [3:0] SCH_STROBE_DIV = 4'h3;
  localparam logic [3:0] SCH_DIV_ZERO = 4'h0;
  localparam logic [3:0] SCH_DIV_ONE = 4'h1;
  localparam logic [SCH_CNT_W-1:0] SCH_CNT_ZERO = 12'h000;
  localparam logic [SCH_CNT_W-1:0] SCH_CNT_ONE = 12'h001;
  // idle levels of the synchronised pins {task_n, io, we_n, iowr_n, stop}
  // so that no false strobe edge or mode glitch follows reset
  localparam logic [4:0] SCH_PIN_IDLE = 5'h16;
endpackage

/* core/sch_sync.sv */
// two flip-flop synchroniser bank for asynchronous pins
`timescale 1ns/100ps
module sch_sync #(
  parameter int W = 1,
  // per bit reset level, set to the idle level of each pin
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // first stage, read only by second stage
  logic [W-1:0] meta_q;

  ////////////////////////////////////////////////////////////////////////
  // two stages per bit
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clock)
      begin
        if (srst)
        begin
          // idle level, avoids a false edge after reset
          meta_q[i] <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end
        else
        begin
          meta_q[i] <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule

/* dv/sch_host_model.sv */
// host controller model that latches ultra dma words sent by the device
`timescale 1ns/100ps
module sch_host_model (
  input wire logic clock,
  input wire logic stop,
  input wire logic dstrobe,
  input wire logic [sch_pkg::SCH_DATA_W-1:0] data_out,
  output int words,
  output logic [sch_pkg::SCH_DATA_W-1:0] last_word
);
  import sch_pkg::*;
  logic prev_q;
  initial
  begin
    words = 0;
    prev_q = 1'b0;
  end
  // one word on every strobe edge, rising or falling, unless stopping
  always @(posedge clock)
  begin
    prev_q <= dstrobe;
    if (!stop && dstrobe !== prev_q)
    begin
      words <= words + 1;
      last_word <= data_out;
    end
  end
endmodule

/* dv/tb_storage_card_host_handshake.sv */
// self-checking bench for the host handshake block
`timescale 1ns/100ps
module tb_storage_card_host_handshake;
  import sch_pkg::*;
  logic clock = 0, srst = 1, mode_sel_task_n = 1, mode_sel_io = 0, we_n = 1, iowr_n = 1, stop = 0;
  logic core_busy = 0, core_hold = 0, core_word_cycle = 0, core_port16 = 0;
  logic udma_start_recv = 0, udma_start_send = 0, core_recv_pause = 0, core_send_pause = 0;
  logic [SCH_DATA_W-1:0] core_send_data = 16'hA5C3, data_out, last_word;
  logic wait_n, ready, ddmardy_n, dstrobe, wp, iois16_n, iocs16_n, cfg_write, task_write, send_taken, burst_done;
  int mismatches = 0, checks = 0, cycles = 0, cfg_n = 0, task_n = 0, taken_n = 0, done_n = 0, words, w;
  sch_host_port dut_u (.clock(clock), .srst(srst), .mode_sel_task_n(mode_sel_task_n),
    .mode_sel_io(mode_sel_io), .we_n(we_n), .iowr_n(iowr_n), .stop(stop), .core_busy(core_busy),
    .core_hold(core_hold), .core_word_cycle(core_word_cycle), .core_port16(core_port16),
    .udma_start_recv(udma_start_recv), .udma_start_send(udma_start_send),
    .core_recv_pause(core_recv_pause), .core_send_pause(core_send_pause),
    .core_send_data(core_send_data), .wait_n(wait_n), .ready(ready), .ddmardy_n(ddmardy_n),
    .dstrobe(dstrobe), .data_out(data_out), .wp(wp), .iois16_n(iois16_n), .iocs16_n(iocs16_n),
    .cfg_write(cfg_write), .task_write(task_write), .send_taken(send_taken), .burst_done(burst_done));
  sch_host_model host_u (.clock(clock), .stop(stop), .dstrobe(dstrobe), .data_out(data_out),
    .words(words), .last_word(last_word));
  initial
  begin
    forever #5 clock = ~clock;
  end
  // pulse counters and hang limit
  always @(posedge clock)
  begin
    cycles++;
    cfg_n += (cfg_write === 1'b1);
    task_n += (task_write === 1'b1);
    taken_n += (send_taken === 1'b1);
    done_n += (burst_done === 1'b1);
    if (cycles == 3000)
    begin
      mismatches++;
      complete_run();
    end
  end
  task step(input int n);
    repeat (n) @(negedge clock);
  endtask
  task check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task set_mode(input logic tn, input logic io);
    mode_sel_task_n = tn;
    mode_sel_io = io;
    step(8);
    cfg_n = 0;
    task_n = 0;
  endtask
  task strobe(input logic on_we);
    if (on_we)
      we_n = 0;
    else
      iowr_n = 0;
    step(3);
    we_n = 1;
    iowr_n = 1;
    step(8);
  endtask
  task reset_init;
    step(10);
    srst = 0;
    step(100);
    check(16'(ready), 16'h0000);
    check(16'(wp), 16'h0001);
    step(110);
    check(16'(wp), 16'h0000);
    check(16'(ready), 16'h0001);
    core_busy = 1;
    step(2);
    check(16'(ready), 16'h0000);
    core_busy = 0;
  endtask
  task mem_mode;
    set_mode(1, 0);
    strobe(1);
    strobe(0);
    check(16'(task_n), 16'h0001);
    core_hold = 1;
    core_port16 = 1;
    step(2);
    check(16'(wait_n), 16'h0000);
    check(16'(iois16_n), 16'h0001);
    core_hold = 0;
    core_port16 = 0;
  endtask
  task io_mode;
    set_mode(1, 1);
    strobe(1);
    check(16'(cfg_n), 16'h0001);
    check(16'(task_n), 16'h0000);
    strobe(0);
    check(16'(task_n), 16'h0001);
    core_port16 = 1;
    step(2);
    check(16'(iois16_n), 16'h0000);
    core_port16 = 0;
    step(2);
    check(16'(iois16_n), 16'h0001);
  endtask
  task task_mode;
    set_mode(0, 0);
    strobe(1);
    check(16'(cfg_n + task_n), 16'h0000);
    core_hold = 1;
    step(2);
    check(16'(wait_n), 16'h0000);
    core_hold = 0;
    step(2);
    check(16'(wait_n), 16'h0001);
    core_word_cycle = 1;
    step(2);
    check(16'(iocs16_n), 16'h0000);
    core_word_cycle = 0;
    step(2);
    check(16'(iocs16_n), 16'h0001);
  endtask
  task udma_recv;
    core_hold = 1;
    udma_start_recv = 1;
    step(1);
    udma_start_recv = 0;
    step(3);
    check(16'(ddmardy_n), 16'h0000);
    check(16'(wait_n), 16'h0001);
    core_recv_pause = 1;
    step(3);
    check(16'(ddmardy_n), 16'h0001);
    core_recv_pause = 0;
    step(3);
    check(16'(ddmardy_n), 16'h0000);
    done_n = 0;
    stop = 1;
    step(6);
    check(16'(done_n), 16'h0001);
    check(16'(ddmardy_n), 16'h0001);
    stop = 0;
    core_hold = 0;
    step(4);
  endtask
  task udma_send;
    done_n = 0;
    udma_start_send = 1;
    step(1);
    udma_start_send = 0;
    step(40);
    check(16'(words >= 8), 16'h0001);
    check(last_word, 16'hA5C3);
    core_send_data = 16'h5A3C;
    core_send_pause = 1;
    step(4);
    w = words;
    step(20);
    check(16'(words), 16'(w));
    core_send_pause = 0;
    step(12);
    check(16'(words > w), 16'h0001);
    check(last_word, 16'h5A3C);
    stop = 1;
    step(8);
    w = taken_n;
    check(16'(done_n), 16'h0001);
    step(12);
    check(16'(taken_n), 16'(w));
    check(16'(dstrobe), 16'h0000);
    stop = 0;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    reset_init();
    mem_mode();
    io_mode();
    task_mode();
    udma_recv();
    udma_send();
    complete_run();
  end
endmodule
